/* core/flash_defs.vh */
// Constants for the serial flash command and status block.
// Assumes a 100 MHz system clock and an 8-bit SPI opcode stream.
`ifndef FLASH_DEFS_VH
`define FLASH_DEFS_VH
`define OP_WREN 8'h06
`define OP_VWREN 8'h50
`define OP_WRDI 8'h04
`define OP_RDSR_LO 8'h05
`define OP_RDSR_HI 8'h35
`define OP_WRSR_LO 8'h01
`define OP_WRSR_HI 8'h31
`define OP_READ 8'h03
`define OP_FREAD 8'h0b
`define OP_DREAD 8'h3b
`define SL_WR_MASK 8'hfc
`define SH_WR_MASK 8'h7f
`define SH_OTP_NV 8'h3c
`define SH_OTP_VOL 8'h3d
`define STATUS_LOW_RST 8'h00
`define STATUS_HIGH_RST 8'h00
`define CLK_MHZ 100
`define STATUS_WRITE_TIME_US 10000
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

/* core/serial_flash_cmd_status_read.v */
// Serial flash instruction interpreter with status registers and reads.
// Assumes SPI pins arrive asynchronously and a memory answers on sys_clk.
//
// What this block does
// - Write-enable opcode sets the write latch.
// - Latch-gated instructions accepted only when latch set.
// - Opcode bits sampled on rising clock edges.
// - Volatile enable arms volatile path, latch untouched.
// - Write-disable clears latch and volatile arm.
// - Latch cleared at power-up and cycle end.
// - Two opcodes read either status byte MSB first.
// - Status reads accepted at any time, even busy.
// - Status byte repeats until chip select rises.
// - Status write changes only writable bits.
// - Lock bits sticky; volatile write cannot clear them.
// - Non-volatile status write needs latch set first.
// - Volatile status write leaves latch unchanged.
// - Status write discarded unless 8 bits, or 16 with low opcode.
// - Eight bits of low opcode update low only.
// - Non-volatile write runs timed busy cycle.
// - Volatile write applies at once, never busy.
// - Read latches 24-bit address, streams byte out.
// - Address increments after every byte.
// - Array read ignored while busy.
// - Fast read adds eight dummy clocks.
// - Dual read outputs two bits per clock.
// - All bytes shifted most significant bit first.
// - In dual read, line 1 carries odd bits, line 0 even; single reads use line 1 only.
`timescale 1ns/1ns
`include "flash_defs.vh"

// ------------------------------------------------------------
// Byte FIFO between the array fetch and the output shifter
// ------------------------------------------------------------
// Depth must be a power of two so the pointers wrap by themselves.
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH[AW:0];
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  // Handshakes and honest full and empty flags.
  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage is written without reset; only the pointers matter.
  always @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count.
  always @(posedge clk)
  begin
    if (rst || flush)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ------------------------------------------------------------
// Instruction interpreter
// ------------------------------------------------------------
module serial_flash_cmd_status_read #(
  parameter [19:0] SWR_CYCLES = `STATUS_WRITE_TIME_US * `CLK_MHZ
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire chip_select_n,
  input wire spi_clk,
  input wire io0_in,
  output reg io0_out,
  output reg io0_oe_n,
  output reg io1_out,
  output reg io1_oe_n,
  output reg mem_rd_r,
  output reg [23:0] mem_addr_r,
  input wire [7:0] mem_rdata,
  input wire mem_rvalid
);
  localparam [2:0] ST_CMD = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_DUMMY = 3'd2;
  localparam [2:0] ST_OUT = 3'd3;
  localparam [2:0] ST_SWR = 3'd4;
  localparam [2:0] ST_IGN = 3'd5;
  localparam [2:0] ST_DONE = 3'd6;

  reg cs_s1_r, cs_s2_r, cs_d_r;
  reg ck_s1_r, ck_s2_r, ck_d_r;
  reg d0_s1_r, d0_s2_r;
  reg [2:0] st_r;
  reg [4:0] bcnt_r;
  reg [7:0] in_sr_r;
  reg [7:0] op_r;
  reg [23:0] addr_r;
  reg dual_r;
  reg arr_r;
  reg sel_hi_r;
  reg [2:0] obit_r;
  reg [7:0] out_sr_r;
  reg [7:0] swr_a_r;
  reg [7:0] swr_b_r;
  reg [7:0] stat_lo_r;
  reg [7:0] stat_hi_r;
  reg [7:0] nv_lo_r;
  reg [7:0] nv_hi_r;
  reg [7:0] pend_lo_r;
  reg [7:0] pend_hi_r;
  reg write_latch_r;
  reg vol_arm_r;
  reg busy_r;
  reg [19:0] swr_cnt_r;
  reg fetch_on_r;
  reg fetch_pend_r;
  reg [23:0] fetch_addr_r;

  wire ck_rise;
  wire ck_fall;
  wire cs_rise;
  wire [7:0] in_nxt;
  wire [7:0] stat_byte;
  wire [7:0] src;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_q;
  wire fifo_pop;
  wire fifo_flush;
  wire swr_len_ok;
  wire [7:0] new_lo;
  wire [7:0] new_hi;

  // Keep the writable bits from new, hold the rest, and never let a
  // sticky bit fall back from one to zero.
  function [7:0] merge;
    input [7:0] old;
    input [7:0] nw;
    input [7:0] wmask;
    input [7:0] sticky;
    begin
      merge = (old & ~wmask) | (nw & wmask) | (old & sticky);
    end
  endfunction

  // Edge detection compares the second synchroniser stage with its delayed copy.
  assign ck_rise = ck_s2_r & ~ck_d_r & ~cs_s2_r;
  assign ck_fall = ~ck_s2_r & ck_d_r & ~cs_s2_r;
  assign cs_rise = cs_s2_r & ~cs_d_r;
  assign in_nxt = {in_sr_r[6:0], d0_s2_r};

  // Live status bytes; busy and latch are seen at every repeat.
  assign stat_byte = sel_hi_r ? {1'b0, stat_hi_r[6:0]} :
                     {stat_lo_r[7:2], write_latch_r, busy_r};
  assign fifo_pop = ck_fall & (st_r == ST_OUT) & arr_r &
                    (obit_r == 3'd0) & fifo_out_valid;
  assign src = (obit_r == 3'd0) ? (arr_r ? fifo_q : stat_byte) : out_sr_r;
  assign fifo_flush = cs_rise;

  // Status write length check and composed new values.
  assign swr_len_ok = ((op_r == `OP_WRSR_LO) &&
                       (bcnt_r == 5'd8 || bcnt_r == 5'd16)) ||
                      ((op_r == `OP_WRSR_HI) && bcnt_r == 5'd8);
  assign new_lo = (op_r == `OP_WRSR_LO) ? swr_a_r : stat_lo_r;
  assign new_hi = (op_r == `OP_WRSR_HI) ? swr_a_r :
                  (bcnt_r == 5'd16) ? swr_b_r : stat_hi_r;

  // The prefetch buffer lets array fetches run ahead of the link.
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(sys_clk),
    .rst(sys_rst),
    .flush(fifo_flush),
    .in_valid(mem_rvalid & fetch_on_r),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_q)
  );

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Chip select resets high so a frame never starts out of reset.
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_d_r <= 1'b0;
      d0_s1_r <= 1'b0;
      d0_s2_r <= 1'b0;
    end
    else
    begin
      cs_s1_r <= chip_select_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
      ck_s1_r <= spi_clk;
      ck_s2_r <= ck_s1_r;
      ck_d_r <= ck_s2_r;
      d0_s1_r <= io0_in;
      d0_s2_r <= d0_s1_r;
    end
  end

  // ------------------------------------------------------------
  // Array fetch engine
  // ------------------------------------------------------------
  // One request in flight at a time, so a free slot at issue is
  // still free when the answer lands.
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mem_rd_r <= 1'b0;
      mem_addr_r <= 24'h000000;
      fetch_pend_r <= 1'b0;
      fetch_addr_r <= 24'h000000;
    end
    else
    begin
      mem_rd_r <= 1'b0;
      if (mem_rvalid)
      begin
        fetch_pend_r <= 1'b0;
      end
      if (st_r == ST_ADDR && ck_rise && bcnt_r == 5'd23)
      begin
        fetch_addr_r <= {addr_r[22:0], d0_s2_r};
      end
      else if (fetch_on_r && !fetch_pend_r && !mem_rd_r &&
               fifo_in_ready && !cs_rise)
      begin
        mem_rd_r <= 1'b1;
        mem_addr_r <= fetch_addr_r;
        fetch_addr_r <= fetch_addr_r + 24'h000001;
        fetch_pend_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Instruction sequencer, status registers and output shifter
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_r <= ST_CMD;
      bcnt_r <= 5'd0;
      in_sr_r <= 8'h00;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      dual_r <= 1'b0;
      arr_r <= 1'b0;
      sel_hi_r <= 1'b0;
      obit_r <= 3'd0;
      out_sr_r <= 8'h00;
      swr_a_r <= 8'h00;
      swr_b_r <= 8'h00;
      stat_lo_r <= `STATUS_LOW_RST;
      stat_hi_r <= `STATUS_HIGH_RST;
      nv_lo_r <= `STATUS_LOW_RST;
      nv_hi_r <= `STATUS_HIGH_RST;
      pend_lo_r <= 8'h00;
      pend_hi_r <= 8'h00;
      write_latch_r <= 1'b0;
      vol_arm_r <= 1'b0;
      busy_r <= 1'b0;
      swr_cnt_r <= 20'h00000;
      fetch_on_r <= 1'b0;
      io0_out <= 1'b0;
      io0_oe_n <= 1'b1;
      io1_out <= 1'b0;
      io1_oe_n <= 1'b1;
    end
    else
    begin
      // Self-timed non-volatile cycle; commits at its end.
      if (busy_r)
      begin
        swr_cnt_r <= swr_cnt_r + 20'h00001;
        if (swr_cnt_r == SWR_CYCLES - 20'h00001)
        begin
          busy_r <= 1'b0;
          write_latch_r <= 1'b0;
          nv_lo_r <= pend_lo_r;
          nv_hi_r <= pend_hi_r;
          stat_lo_r <= pend_lo_r;
          stat_hi_r <= pend_hi_r;
        end
      end
      if (cs_rise)
      begin
        // Frame end: execute the completed instruction, release pins.
        st_r <= ST_CMD;
        bcnt_r <= 5'd0;
        obit_r <= 3'd0;
        fetch_on_r <= 1'b0;
        io0_oe_n <= 1'b1;
        io1_oe_n <= 1'b1;
        if (st_r == ST_DONE)
        begin
          if (op_r == `OP_WREN)
          begin
            write_latch_r <= 1'b1;
          end
          else if (op_r == `OP_VWREN)
          begin
            vol_arm_r <= 1'b1;
          end
          else if (op_r == `OP_WRDI)
          begin
            write_latch_r <= 1'b0;
            vol_arm_r <= 1'b0;
          end
        end
        else if (st_r == ST_SWR)
        begin
          // An arm is used up by any status write attempt.
          vol_arm_r <= 1'b0;
          if (swr_len_ok && vol_arm_r)
          begin
            stat_lo_r <= merge(stat_lo_r, new_lo, `SL_WR_MASK,
                               8'h00);
            stat_hi_r <= merge(stat_hi_r, new_hi, `SH_WR_MASK,
                               `SH_OTP_VOL);
          end
          else if (swr_len_ok && write_latch_r)
          begin
            busy_r <= 1'b1;
            swr_cnt_r <= 20'h00000;
            pend_lo_r <= merge(nv_lo_r, new_lo, `SL_WR_MASK,
                               8'h00);
            pend_hi_r <= merge(nv_hi_r, new_hi, `SH_WR_MASK,
                               `SH_OTP_NV);
          end
        end
      end
      else if (ck_rise)
      begin
        case (st_r)
          ST_CMD:
          begin
            in_sr_r <= in_nxt;
            bcnt_r <= bcnt_r + 5'd1;
            if (bcnt_r == 5'd7)
            begin
              op_r <= in_nxt;
              bcnt_r <= 5'd0;
              dual_r <= (in_nxt == `OP_DREAD);
              sel_hi_r <= (in_nxt == `OP_RDSR_HI);
              arr_r <= 1'b0;
              if (in_nxt == `OP_RDSR_LO || in_nxt == `OP_RDSR_HI)
              begin
                st_r <= ST_OUT;
              end
              else if (busy_r)
              begin
                st_r <= ST_IGN;
              end
              else if (in_nxt == `OP_WREN || in_nxt == `OP_VWREN ||
                       in_nxt == `OP_WRDI)
              begin
                st_r <= ST_DONE;
              end
              else if (in_nxt == `OP_WRSR_LO || in_nxt == `OP_WRSR_HI)
              begin
                st_r <= ST_SWR;
              end
              else if (in_nxt == `OP_READ || in_nxt == `OP_FREAD ||
                       in_nxt == `OP_DREAD)
              begin
                st_r <= ST_ADDR;
              end
              else
              begin
                st_r <= ST_IGN;
              end
            end
          end
          ST_ADDR:
          begin
            addr_r <= {addr_r[22:0], d0_s2_r};
            bcnt_r <= bcnt_r + 5'd1;
            if (bcnt_r == 5'd23)
            begin
              bcnt_r <= 5'd0;
              arr_r <= 1'b1;
              fetch_on_r <= 1'b1;
              st_r <= (op_r == `OP_READ) ? ST_OUT : ST_DUMMY;
            end
          end
          ST_DUMMY:
          begin
            // Inputs during dummy clocks are not looked at.
            bcnt_r <= bcnt_r + 5'd1;
            if (bcnt_r == 5'd7)
            begin
              st_r <= ST_OUT;
            end
          end
          ST_SWR:
          begin
            in_sr_r <= in_nxt;
            if (bcnt_r != 5'd31)
            begin
              bcnt_r <= bcnt_r + 5'd1;
            end
            if (bcnt_r == 5'd7)
            begin
              swr_a_r <= in_nxt;
            end
            if (bcnt_r == 5'd15)
            begin
              swr_b_r <= in_nxt;
            end
          end
          ST_DONE:
          begin
            // Extra clocks after a one-byte opcode void it.
            st_r <= ST_IGN;
          end
          default:
          begin
            st_r <= st_r;
          end
        endcase
      end
      else if (ck_fall && st_r == ST_OUT)
      begin
        // A new byte is taken at each byte boundary; status bytes
        // repeat for as long as the clock runs.
        io1_oe_n <= 1'b0;
        io0_oe_n <= ~dual_r;
        io1_out <= src[7];
        if (dual_r)
        begin
          io0_out <= src[6];
          out_sr_r <= {src[5:0], 2'b00};
          obit_r <= obit_r + 3'd2;
        end
        else
        begin
          out_sr_r <= {src[6:0], 1'b0};
          obit_r <= obit_r + 3'd1;
        end
      end
    end
  end
endmodule

/* testbench/serial_flash_cmd_status_read_checker.sv */
// Pin-level checker for the flash command block.
// Assumes the SPI pins reach sys_clk through two-flop synchronizers.
`timescale 1ns/1ns
module flash_checker #(
  parameter [19:0] SWR_CYCLES = 20'd50
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire chip_select_n,
  input wire spi_clk,
  input wire io0_in,
  input wire io0_out,
  input wire io0_oe_n,
  input wire io1_out,
  input wire io1_oe_n,
  input wire mem_rd_r,
  input wire [23:0] mem_addr_r,
  input wire [7:0] mem_rdata,
  input wire mem_rvalid
);
  // ------------------------------------------------------------
  // Pin relations
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Six quiet cycles outlast the synchronizer and the edge detect.
  sequence cs_idle;
    chip_select_n [*6];
  endsequence
  sequence clk_high;
    (!chip_select_n && spi_clk) [*2];
  endsequence
  release_out_a: assert property ($rose(chip_select_n) |-> ##[1:5] io1_oe_n && io0_oe_n)
    else $error("outputs still driven after deselect");
  idle_quiet_a: assert property (cs_idle |-> io1_oe_n && io0_oe_n)
    else $error("output driven while deselected");
  fetch_stop_a: assert property (chip_select_n [*8] |-> !mem_rd_r)
    else $error("array fetch outside a frame");
  fetch_space_a: assert property (mem_rd_r |=> !mem_rd_r [*2])
    else $error("array fetches too close");
  fetch_frame_a: assert property (mem_rd_r |-> $past(!chip_select_n, 5))
    else $error("array fetch without a selected frame");
  fall_only_a: assert property (clk_high |-> $stable(io1_out) && $stable(io0_out))
    else $error("output changed while clock high");
  dual_pair_a: assert property (!io0_oe_n |-> !io1_oe_n)
    else $error("line 0 driven without line 1");
  start_fall_a: assert property ($fell(io1_oe_n) |-> !spi_clk && !chip_select_n)
    else $error("output started off a falling edge");
endmodule

bind serial_flash_cmd_status_read flash_checker #(.SWR_CYCLES(SWR_CYCLES)) chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
  .spi_clk(spi_clk), .io0_in(io0_in), .io0_out(io0_out),
  .io0_oe_n(io0_oe_n), .io1_out(io1_out), .io1_oe_n(io1_oe_n),
  .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r), .mem_rdata(mem_rdata),
  .mem_rvalid(mem_rvalid));

/* testbench/mem_model.sv */
// Array model answering byte fetches of the flash block.
// Assumes one outstanding fetch; the answer comes three cycles later.
`timescale 1ns/1ns
module mem_model (
  input wire sys_clk,
  input wire sys_rst,
  input wire mem_rd_r,
  input wire [23:0] mem_addr_r,
  output logic [7:0] mem_rdata = 8'h00,
  output logic mem_rvalid = 1'b0
);
  // ------------------------------------------------------------
  // Fetch answer
  // ------------------------------------------------------------
  reg [23:0] addr_r = 24'h000000;
  reg [1:0] wait_r = 2'h0;
  // Data wanders between answers so a stale byte is never a match.
  always @(posedge sys_clk)
  begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (sys_rst)
      wait_r <= 2'h0;
    else if (mem_rd_r)
    begin
      addr_r <= mem_addr_r;
      wait_r <= 2'h2;
    end
    else if (wait_r != 2'h0)
    begin
      wait_r <= wait_r - 2'h1;
      if (wait_r == 2'h1)
      begin
        mem_rvalid <= 1'b1;
        mem_rdata <= addr_r[7:0] ^ 8'ha5;
      end
    end
  end
endmodule

/* testbench/serial_flash_cmd_status_read_tb.sv */
// Bench for the flash command block: SPI host frames and checks.
// Assumes the array model returns address low byte xor a5.
`timescale 1ns/1ns
`include "flash_defs.vh"
module serial_flash_cmd_status_read_tb;
  // ------------------------------------------------------------
  // Pins and parts
  // ------------------------------------------------------------
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg chip_select_n = 1'b1;
  reg spi_clk = 1'b0;
  reg host_d = 1'b0;
  reg drv = 1'b0;
  reg [15:0] rx = 16'h0000;
  wire io0_in, io0_out, io0_oe_n, io1_out, io1_oe_n;
  wire mem_rd_r, mem_rvalid;
  wire [23:0] mem_addr_r;
  wire [7:0] mem_rdata;
  integer n_fail = 0;
  integer n_tests = 0;
  // The shared line follows the device only while it drives.
  assign io0_in = io0_oe_n ? host_d : io0_out;
  always #5 sys_clk = ~sys_clk;
  serial_flash_cmd_status_read #(.SWR_CYCLES(20'd2000)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .spi_clk(spi_clk), .io0_in(io0_in), .io0_out(io0_out),
    .io0_oe_n(io0_oe_n), .io1_out(io1_out), .io1_oe_n(io1_oe_n),
    .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
  mem_model mem (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input string what, input [15:0] exp, input [15:0] got);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("wrong value %0s: expected %h, seen %h", what, exp, got);
    end
  end
  endtask
  // One frame: nt bits out MSB first, then nr clocks of answer.
  task spi(input [47:0] tx, input integer nt, input integer nr,
    input reg dl);
    integer i;
  begin
    rx = 16'h0000;
    drv = 1'b0;
    chip_select_n <= 1'b0;
    #60;
    for (i = 0; i < nt + nr; i = i + 1)
    begin
      // After the last bit the host lets go; the line toggles.
      host_d <= (i < nt) ? tx[nt-1-i] : ~host_d;
      #62 spi_clk <= 1'b1;
      if (i >= nt)
      begin
        rx = dl ? {rx[13:0], io1_out, io0_out} : {rx[14:0], io1_out};
        drv = drv | ~io1_oe_n;
      end
      #63 spi_clk <= 1'b0;
    end
    #60 chip_select_n <= 1'b1;
    #100;
  end
  endtask
  task cmd(input [47:0] tx, input integer nt);
    spi(tx, nt, 0, 1'b0);
  endtask
  // Reads two bytes, so the register must repeat itself.
  task st(input [7:0] op, input [7:0] v);
  begin
    spi({40'h0, op}, 8, 16, 1'b0);
    chk("status", {v, v}, rx);
  end
  endtask
  task summarize;
  begin
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    st(`OP_RDSR_LO, 8'h00);
    st(`OP_RDSR_HI, 8'h00);
    cmd(`OP_WREN, 8);
    st(`OP_RDSR_LO, 8'h02);
    cmd(`OP_WRDI, 8);
    st(`OP_RDSR_LO, 8'h00);
    cmd({`OP_WRSR_LO, 8'hff}, 16);
    st(`OP_RDSR_LO, 8'h00);
    $display("test latch done");
    cmd(`OP_WREN, 8);
    cmd({`OP_WRSR_LO, 4'hf}, 12);
    st(`OP_RDSR_LO, 8'h02);
    cmd({`OP_WRSR_LO, 16'hffff}, 24);
    st(`OP_RDSR_LO, 8'h03);
    spi({`OP_READ, 24'h000010}, 32, 8, 1'b0);
    chk("drive", 16'h0000, {15'h0, drv});
    #20000;
    st(`OP_RDSR_LO, 8'hfc);
    st(`OP_RDSR_HI, 8'h7f);
    $display("test status write done");
    cmd(`OP_VWREN, 8);
    cmd({`OP_WRSR_LO, 8'h00}, 16);
    st(`OP_RDSR_LO, 8'h00);
    st(`OP_RDSR_HI, 8'h7f);
    cmd(`OP_VWREN, 8);
    cmd({`OP_WRSR_HI, 8'h00}, 16);
    st(`OP_RDSR_HI, 8'h3d);
    cmd(`OP_VWREN, 8);
    cmd(`OP_WRDI, 8);
    cmd({`OP_WRSR_LO, 8'hff}, 16);
    st(`OP_RDSR_LO, 8'h00);
    $display("test volatile done");
    spi({`OP_READ, 24'h000010}, 32, 16, 1'b0);
    chk("read", 16'hb5b4, rx);
    spi({`OP_FREAD, 24'h000020, 8'h00}, 40, 16, 1'b0);
    chk("fast", 16'h8584, rx);
    spi({`OP_DREAD, 24'h0000ff, 8'h00}, 40, 8, 1'b1);
    chk("dual", 16'h5aa5, rx);
    $display("test array read done");
    summarize;
  end
  // The tests need about 110 us; this limit is about four and a half times that.
  initial
  begin
    #500000;
    n_fail = n_fail + 1;
    summarize;
  end
endmodule
